// File: shared/monitor_sample_map.svh
// Register offsets, field positions and reset values of the sample command block.
// Assumes byte-wide register access delivered by the link's frame layer.
`ifndef MONITOR_SAMPLE_MAP_SVH
`define MONITOR_SAMPLE_MAP_SVH

// ==========================================
// Byte offsets
`define REV_HI_OFS 8'h00
`define REV_LO_OFS 8'h01
`define CMD_OFS 8'h02
`define CHSEL_B3_OFS 8'h03
`define CHSEL_B2_OFS 8'h04
`define CHSEL_B1_OFS 8'h05
`define CHSEL_B0_OFS 8'h06
`define AVG_OFS 8'h07

// ==========================================
// Field positions
`define RESP_ADDR_MSB 4
`define CELL_SEL_LSB 16
`define CELL_SEL_MSB 31
`define AUX_SEL_LSB 8
`define REF_SEL_BIT 2
`define MODULE_SEL_BIT 1

// ==========================================
// Reset values
`define CHSEL_RESET 32'h0000_0000
`define AVG_RESET 8'h00
`define UNDEF_READ 8'h00

`endif

// File: shared/monitor_sample_pkg.sv
// Types shared by the sample command block and its surroundings.
// Assumes the frame layer decodes kind and reply request of each frame.
package monitor_sample_pkg;

  // ==========================================
  // Frame kinds
  typedef enum logic [1:0] {
    KIND_SINGLE = 2'b00,
    KIND_GROUP = 2'b01,
    KIND_BCAST = 2'b10
  } frame_kind_t;

  // ==========================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef struct packed {
    logic [4:0] chan;
    logic second;
    logic [7:0] avg;
  } conv_req_t;

  // ==========================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TURN = 3'b001,
    ST_SCAN = 3'b010,
    ST_CONV = 3'b011,
    ST_HI = 3'b100,
    ST_LO = 3'b101,
    ST_NEXT = 3'b110
  } seq_state_t;

endpackage

// File: src/monitor_sample_command.sv
// Sample command interpreter: register writes from frames, conversion sequencing, reply bytes.
// Assumes a frame layer that delivers decoded byte writes and a converter on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "monitor_sample_map.svh"

// Contract
// RULE1 - Reply-requesting command write executes, returns results
// RULE2 - Reply length follows channel mask bits
// RULE3 - Reply carries conversion results, not registers
// RULE4 - Command register has no readback
// RULE5 - Unwritten mask/averaging keep current values
// RULE6 - Same-frame mask/averaging writes apply first
// RULE7 - Values MSB first, mask order, cell16 down
// RULE8 - Clear mask bits send nothing
// RULE9 - Host writes command bits 7:6 as zero
// RULE10 - Group responder address names highest replier
// RULE11 - Responder address ignored for other kinds
// RULE12 - Revision: digital high byte, analog low
// RULE13 - Cell select occupies mask bits 16-31
// RULE14 - Aux select starts at mask bit 8
// RULE15 - Module sum: two conversions, average returned
// RULE16 - Reference: 4.5 V value, then ground
// RULE17 - Execute only after whole frame accepted
// RULE18 - Wait for lower responders before replying
module monitor_sample_command #(
  parameter logic [7:0] DIGITAL_DIE_REVISION = 8'h01, // Arbitrary value
  parameter logic [7:0] ANALOG_DIE_REVISION = 8'h01 // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [4:0] dev_addr_in,
  input wire logic wr_valid_in,
  input wire monitor_sample_pkg::reg_write_t wr_in,
  input wire logic frame_end_in,
  input wire logic frame_ok_in,
  input wire monitor_sample_pkg::frame_kind_t frame_kind_in,
  input wire logic frame_reply_in,
  input wire logic [7:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  output logic conv_start_out,
  output monitor_sample_pkg::conv_req_t conv_req_out,
  input wire logic conv_done_in,
  input wire logic [15:0] conv_result_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  input wire logic lower_done_in,
  output logic reply_done_out,
  output logic busy_out
);
  import monitor_sample_pkg::*;

  // ==========================================
  // Registers and pending command
  logic [31:0] chan_select, next_chan_select;
  logic [7:0] averaging_setting, next_averaging_setting;
  logic cmd_pending, next_cmd_pending;
  logic [4:0] resp_addr, next_resp_addr;

  always_comb begin
    next_chan_select = chan_select;
    next_averaging_setting = averaging_setting;
    next_cmd_pending = cmd_pending;
    next_resp_addr = resp_addr;
    // Pending command is consumed or dropped at frame end (see RULE17)
    // Cleared first so a command byte in the same cycle still sets it
    if (frame_end_in) begin
      next_cmd_pending = 1'b0;
    end
    if (wr_valid_in) begin
      // Writes land at once, so a later command in the frame sees them (see RULE6)
      case (wr_in.addr)
        `CHSEL_B3_OFS: next_chan_select[31:24] = wr_in.data; // see RULE13
        `CHSEL_B2_OFS: next_chan_select[23:16] = wr_in.data;
        `CHSEL_B1_OFS: next_chan_select[15:8] = wr_in.data; // see RULE14
        `CHSEL_B0_OFS: next_chan_select[7:0] = wr_in.data;
        `AVG_OFS: next_averaging_setting = wr_in.data;
        `CMD_OFS: begin
          // Bits 7:6 are left to the host to zero and are not decoded (see RULE9)
          next_cmd_pending = 1'b1;
          next_resp_addr = wr_in.data[`RESP_ADDR_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chan_select <= `CHSEL_RESET;
      averaging_setting <= `AVG_RESET;
      cmd_pending <= 1'b0;
      resp_addr <= 5'h00;
    end else if (ce_in) begin
      chan_select <= next_chan_select;
      averaging_setting <= next_averaging_setting;
      cmd_pending <= next_cmd_pending;
      resp_addr <= next_resp_addr;
    end
  end

  // ==========================================
  // Register reads
  logic [7:0] next_rd_data;

  always_comb begin
    case (rd_addr_in)
      `REV_HI_OFS: next_rd_data = DIGITAL_DIE_REVISION; // see RULE12
      `REV_LO_OFS: next_rd_data = ANALOG_DIE_REVISION; // see RULE12
      `CHSEL_B3_OFS: next_rd_data = chan_select[31:24];
      `CHSEL_B2_OFS: next_rd_data = chan_select[23:16];
      `CHSEL_B1_OFS: next_rd_data = chan_select[15:8];
      `CHSEL_B0_OFS: next_rd_data = chan_select[7:0];
      `AVG_OFS: next_rd_data = averaging_setting;
      // Last command byte is never stored for reading (see RULE4)
      default: next_rd_data = `UNDEF_READ;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (ce_in) begin
      rd_data_out <= next_rd_data;
    end
  end

  // ==========================================
  // Lower-device done pin synchroniser
  // Three stages; the filtered level moves only when stages two and three agree
  logic sync1, sync2, sync3, done_lvl, next_done_lvl, done_rise;

  always_comb begin
    next_done_lvl = (sync2 == sync3) ? sync3 : done_lvl;
    done_rise = next_done_lvl & ~done_lvl;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      done_lvl <= 1'b0;
    end else if (ce_in) begin
      sync1 <= lower_done_in;
      sync2 <= sync1;
      sync3 <= sync2;
      done_lvl <= next_done_lvl;
    end
  end

  // ==========================================
  // Command sequencer
  seq_state_t state, next_state;
  logic [31:0] exec_mask, next_exec_mask;
  logic [7:0] exec_avg, next_exec_avg;
  logic [4:0] idx, next_idx;
  logic phase, next_phase;
  logic [15:0] value, next_value;
  logic [16:0] acc, next_acc;
  logic [7:0] next_tx_data;
  logic next_conv_start, next_reply_done;
  logic is_group, replies, must_wait;

  always_comb begin
    is_group = (frame_kind_in == KIND_GROUP) || (frame_kind_in == KIND_BCAST);
    // Responder address only matters for group and broadcast replies (see RULE10, RULE11)
    replies = frame_reply_in && (!is_group || (dev_addr_in <= resp_addr));
    must_wait = is_group && (dev_addr_in != 5'h00);
    next_state = state;
    next_exec_mask = exec_mask;
    next_exec_avg = exec_avg;
    next_idx = idx;
    next_phase = phase;
    next_value = value;
    next_acc = acc;
    next_tx_data = tx_data_out;
    next_conv_start = 1'b0;
    next_reply_done = 1'b0;
    case (state)
      ST_IDLE: begin
        // Start only on an accepted frame end with a command in it (see RULE1, RULE17)
        if (frame_end_in && frame_ok_in && cmd_pending && replies) begin
          next_exec_mask = chan_select; // see RULE5
          next_exec_avg = averaging_setting;
          next_idx = 5'd31; // see RULE7
          next_phase = 1'b0;
          next_state = must_wait ? ST_TURN : ST_SCAN;
        end
      end
      ST_TURN: begin
        // Lower addresses send first (see RULE18, RULE10)
        if (done_rise) begin
          next_state = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (exec_mask[idx]) begin
          next_state = ST_CONV;
          next_conv_start = 1'b1;
        end else begin
          next_state = ST_NEXT; // see RULE8
        end
      end
      ST_CONV: begin
        if (conv_done_in) begin
          if (idx == 5'(`MODULE_SEL_BIT) && !phase) begin
            // Hold first half of the module sum (see RULE15)
            next_acc = {1'b0, conv_result_in};
            next_phase = 1'b1;
            next_conv_start = 1'b1;
          end else begin
            if (idx == 5'(`MODULE_SEL_BIT)) begin
              next_acc = acc + {1'b0, conv_result_in};
              next_value = next_acc[16:1]; // see RULE15
            end else begin
              next_value = conv_result_in; // see RULE3
            end
            next_tx_data = next_value[15:8]; // see RULE7
            next_state = ST_HI;
          end
        end
      end
      ST_HI: begin
        if (tx_ready_in) begin
          next_tx_data = value[7:0];
          next_state = ST_LO;
        end
      end
      ST_LO: begin
        if (tx_ready_in) begin
          if (idx == 5'(`REF_SEL_BIT) && !phase) begin
            // Ground follows the 4.5 V reference (see RULE16)
            next_phase = 1'b1;
            next_conv_start = 1'b1;
            next_state = ST_CONV;
          end else begin
            next_state = ST_NEXT; // see RULE2
          end
        end
      end
      ST_NEXT: begin
        next_phase = 1'b0;
        if (idx == 5'h00) begin
          next_reply_done = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_idx = idx - 5'h01;
          next_state = ST_SCAN;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      exec_mask <= 32'h0000_0000;
      exec_avg <= 8'h00;
      idx <= 5'h00;
      phase <= 1'b0;
      value <= 16'h0000;
      acc <= 17'h0_0000;
      tx_data_out <= 8'h00;
      conv_start_out <= 1'b0;
      reply_done_out <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      exec_mask <= next_exec_mask;
      exec_avg <= next_exec_avg;
      idx <= next_idx;
      phase <= next_phase;
      value <= next_value;
      acc <= next_acc;
      tx_data_out <= next_tx_data;
      conv_start_out <= next_conv_start;
      reply_done_out <= next_reply_done;
    end
  end

  // Snapshot keeps a reply stable against writes during execution
  assign conv_req_out = '{chan: idx, second: phase, avg: exec_avg};
  assign tx_valid_out = (state == ST_HI) || (state == ST_LO);
  assign busy_out = (state != ST_IDLE);

endmodule
`default_nettype wire

// File: tb/conv_model.sv
// Converter model answering start pulses after a fixed wait.
// Assumes the block's clock and reset; results encode the request.
`timescale 1ns/10ps
`default_nettype none
module conv_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire monitor_sample_pkg::conv_req_t req_in,
  output logic done_out,
  output logic [15:0] result_out
);
  import monitor_sample_pkg::*;
  logic [1:0] wait_cnt;
  logic run;
  // ==========================================
  // Result encodes chan, half and averaging so order errors show up
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run <= 1'b0;
      wait_cnt <= 2'h0;
      done_out <= 1'b0;
      result_out <= 16'h0000;
    end else begin
      done_out <= run && wait_cnt == 2'h0;
      // Invalid outside the done pulse, so a late sample is caught
      result_out <= ~result_out;
      if (start_in) begin
        run <= 1'b1;
        wait_cnt <= 2'h3;
      end else if (run && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (run) begin
        run <= 1'b0;
        result_out <= {req_in.chan, 2'b00, req_in.second, req_in.avg};
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/monitor_sample_command_monitor.sv
// Port checker for the sample command block.
// Assumes it is bound to every instance of the block.
`timescale 1ns/10ps
`default_nettype none
module monitor_sample_checker #(
  parameter logic [7:0] DIGITAL_DIE_REVISION = 8'h01,
  parameter logic [7:0] ANALOG_DIE_REVISION = 8'h01
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic frame_end_in,
  input wire logic frame_ok_in,
  input wire logic frame_reply_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic [7:0] rd_data_out,
  input wire logic conv_start_out,
  input wire monitor_sample_pkg::conv_req_t conv_req_out,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  input wire logic reply_done_out,
  input wire logic busy_out
);
  import monitor_sample_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // Assertions
  start_pulse_a: assert property (conv_start_out && ce_in |=> !conv_start_out)
    else $error("start pulse too long");
  rev_high_a: assert property (ce_in && rd_addr_in == 8'h00 |=> rd_data_out == DIGITAL_DIE_REVISION)
    else $error("bad digital revision");
  rev_low_a: assert property (ce_in && rd_addr_in == 8'h01 |=> rd_data_out == ANALOG_DIE_REVISION)
    else $error("bad analog revision");
  cmd_noread_a: assert property (ce_in && rd_addr_in == 8'h02 |=> rd_data_out == 8'h00)
    else $error("command readable");
  busy_cause_a: assert property ($rose(busy_out) |-> $past(frame_end_in && frame_ok_in && frame_reply_in))
    else $error("busy without frame end");
  tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("reply byte lost");
  tx_busy_a: assert property (tx_valid_out |-> busy_out)
    else $error("reply while idle");
  done_idle_a: assert property (reply_done_out |=> !busy_out)
    else $error("busy after reply");
  conv_wait_a: assert property (conv_start_out |=> $stable(conv_req_out) && !tx_valid_out)
    else $error("reply before result");
  start_busy_a: assert property (conv_start_out |-> busy_out)
    else $error("start while idle");
  cover property (reply_done_out);
  cover property (tx_valid_out && !tx_ready_in);
  cover property (conv_start_out && conv_req_out.chan == 5'h02 && conv_req_out.second);
endmodule
bind monitor_sample_command monitor_sample_checker #(
  .DIGITAL_DIE_REVISION(DIGITAL_DIE_REVISION), .ANALOG_DIE_REVISION(ANALOG_DIE_REVISION)
) i_chk (.clk_in, .rst_in, .ce_in, .frame_end_in, .frame_ok_in, .frame_reply_in, .rd_addr_in,
  .rd_data_out, .conv_start_out,
  .conv_req_out, .tx_valid_out, .tx_data_out, .tx_ready_in, .reply_done_out, .busy_out);
`default_nettype wire

// File: tb/testbench.sv
// Testbench: registers, reply contents and order, group hold-off.
// Assumes the converter model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`define check(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %0t mismatch", $time); end end
module testbench;
  import monitor_sample_pkg::*;
  logic clk_in = 0, rst_in = 1, ce_in = 1, wr_valid_in = 0, frame_end_in = 0;
  logic frame_ok_in = 0, frame_reply_in = 0, tx_ready_in = 0, lower_done_in = 0;
  logic [4:0] dev_addr_in = 5'h03;
  reg_write_t wr_in = '0;
  frame_kind_t frame_kind_in = KIND_SINGLE;
  logic [7:0] rd_addr_in = 8'h00, rd_data_out, tx_data_out;
  logic conv_start_out, conv_done_in, tx_valid_out, reply_done_out, busy_out;
  conv_req_t conv_req_out;
  logic [15:0] conv_result_in;
  logic [7:0] got[$];
  int fails = 0, compares = 0;
  always #5 clk_in = ~clk_in;
  // ==========================================
  // Reply sink stalls every other cycle
  always @(posedge clk_in) begin
    tx_ready_in <= ~tx_ready_in;
    if (tx_valid_out && tx_ready_in) got.push_back(tx_data_out);
  end
  monitor_sample_command i_dut (.clk_in, .rst_in, .ce_in, .dev_addr_in, .wr_valid_in, .wr_in,
    .frame_end_in, .frame_ok_in, .frame_kind_in, .frame_reply_in, .rd_addr_in, .rd_data_out,
    .conv_start_out, .conv_req_out, .conv_done_in, .conv_result_in, .tx_valid_out,
    .tx_data_out, .tx_ready_in, .lower_done_in, .reply_done_out, .busy_out);
  conv_model i_conv (.clk_in, .rst_in, .start_in(conv_start_out), .req_in(conv_req_out),
    .done_out(conv_done_in), .result_out(conv_result_in));
  // ==========================================
  // Tasks
  function automatic logic [15:0] val(logic [4:0] c, logic s, logic [7:0] a);
    return {c, 2'b00, s, a};
  endfunction
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_in);
    wr_in <= '{a, d};
    wr_valid_in <= 1'b1;
    @(posedge clk_in);
    wr_valid_in <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk_in);
    rd_addr_in <= a;
    @(posedge clk_in);
    #1 `check(rd_data_out, e)
  endtask
  task automatic frame(frame_kind_t k, logic ok, logic r);
    got.delete();
    @(posedge clk_in);
    frame_kind_in <= k;
    frame_ok_in <= ok;
    frame_reply_in <= r;
    frame_end_in <= 1'b1;
    @(posedge clk_in);
    frame_end_in <= 1'b0;
    #1;
  endtask
  task automatic reply(logic [7:0] a);
    logic [15:0] exp[$];
    int i;
    // Module sum is the mean of its two halves
    exp = '{val(5'h1F, 1'b0, a), val(5'h08, 1'b0, a), val(5'h02, 1'b0, a),
      val(5'h02, 1'b1, a), val(5'h01, 1'b0, a) + 16'h0080};
    for (i = 0; i < 2000 && reply_done_out !== 1'b1; i++) @(negedge clk_in);
    `check(i < 2000, 1'b1)
    `check(got.size(), 10)
    for (int j = 0; j < 5; j++) `check({got[2*j], got[2*j+1]}, exp[j])
  endtask
  // ==========================================
  // Scenarios
  task automatic test_regs();
    rd(8'h00, 8'h01);
    rd(8'h01, 8'h01);
    wr(8'h07, 8'h5A);
    rd(8'h07, 8'h5A);
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(8'h07, 8'hA5);
    ce_in <= 1'b1;
    rd(8'h07, 8'h5A);
    wr(8'h02, 8'h3F);
    rd(8'h02, 8'h00);
    rd(8'h08, 8'h00);
    frame(KIND_SINGLE, 1'b1, 1'b0);
    `check(busy_out, 1'b0)
    $display("test regs done");
  endtask
  task automatic test_exec();
    wr(8'h03, 8'h80);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h01);
    wr(8'h06, 8'h06);
    wr(8'h07, 8'h33);
    wr(8'h02, 8'h00);
    frame(KIND_SINGLE, 1'b1, 1'b1);
    reply(8'h33);
    wr(8'h02, 8'h00);
    frame(KIND_SINGLE, 1'b0, 1'b1);
    `check(busy_out, 1'b0)
    wr(8'h02, 8'h00);
    frame(KIND_SINGLE, 1'b1, 1'b1);
    reply(8'h33);
    $display("test exec done");
  endtask
  task automatic test_group();
    wr(8'h02, 8'h02);
    frame(KIND_GROUP, 1'b1, 1'b1);
    `check(busy_out, 1'b0)
    wr(8'h02, 8'h05);
    frame(KIND_BCAST, 1'b1, 1'b1);
    repeat (20) @(posedge clk_in);
    `check(got.size(), 0)
    lower_done_in <= 1'b1;
    reply(8'h33);
    @(posedge clk_in);
    lower_done_in <= 1'b0;
    dev_addr_in <= 5'h00;
    wr(8'h02, 8'h05);
    frame(KIND_BCAST, 1'b1, 1'b1);
    reply(8'h33);
    $display("test group done");
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    test_regs();
    test_exec();
    test_group();
    final_report();
  end
  // Whole run is under a thousand cycles
  initial begin
    #200000;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
